/* File: core/bridge_hdr_defs.svh */
`ifndef BRIDGE_HDR_DEFS_SVH
`define BRIDGE_HDR_DEFS_SVH

// ==========================================================
// Byte offsets of the header fields held here
`define OFF_PRIMARY_LATENCY_TIMER 8'h0D
`define OFF_HEADER_LAYOUT_TYPE 8'h0E
`define OFF_SELF_TEST_CONTROL 8'h0F
`define OFF_BASE_ADDRESS_ZERO 8'h10
`define OFF_BASE_ADDRESS_ONE 8'h14
`define OFF_UPSTREAM_BUS_NUMBER 8'h18
`define OFF_DOWNSTREAM_BUS_NUMBER 8'h19
`define OFF_HIGHEST_BUS_NUMBER 8'h1A
`define OFF_DOWNSTREAM_LATENCY_TIMER 8'h1B
`define OFF_IO_WINDOW_BASE 8'h1C

// ==========================================================
// Fixed and reset values
`define VAL_PRIMARY_LATENCY_TIMER 8'h00
`define VAL_HEADER_LAYOUT_TYPE 8'h01
`define VAL_SELF_TEST_CONTROL 8'h00
`define VAL_BASE_ADDRESS 32'h0000_0000
`define VAL_DOWNSTREAM_LATENCY_TIMER 8'h00
`define RST_UPSTREAM_BUS_NUMBER 8'h00
`define RST_DOWNSTREAM_BUS_NUMBER 8'h00
`define RST_HIGHEST_BUS_NUMBER 8'h00
`define RST_IO_CAPABILITY 1'h1
`define RST_IO_BASE_FIELD 4'hF

// ==========================================================
// Field positions inside the I/O base byte
`define IO_CAP_BIT 0
`define IO_FIELD_LSB 4
`define IO_FIELD_MSB 7
`define IO_RSVD_VAL 3'h0

// ==========================================================
// I/O window arithmetic
`define IO_LOW_FILL 12'h000
`define IO_HIGH_FILL 12'hFFF
`define IO_UPPER_ZERO 16'h0000

// ==========================================================
// Bus geometry
`define BYTE_W 8
`define LANES 4
`define WORD_LSB 2
`define MIN_ADDR_W 8

`endif

/* File: core/bridge_hdr_pkg.sv */
package bridge_hdr_pkg;

    // I/O addressing capability encodings
    typedef enum logic [0:0] {
        SIXTEEN_BIT_IO_MODE = 1'b0,
        THIRTY_TWO_BIT_IO_MODE = 1'b1
    } io_mode_type;

    // One byte of configuration data
    typedef logic [7:0] cfg_byte_type;

    // One lane-enable vector of the 32-bit data path
    typedef logic [3:0] lane_en_type;

endpackage

/* File: core/byte_field_reg.sv */
`timescale 1ns/10ps

// ==========================================================
// Writable field with asynchronous reset to a constant
module byte_field_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_we, // Write this field
    input wire logic [WIDTH-1:0] i_d, // New value
    output logic [WIDTH-1:0] o_q // Held value
);

    // Reject a field that cannot exist
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("byte_field_reg width must be at least one");
        end
    endgenerate

    // Field store
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= RESET_VAL;
        end else if (i_we) begin
            o_q <= i_d;
        end
    end

endmodule

/* File: core/bridge_header_bus_io_regs.sv */
`timescale 1ns/10ps
`include "bridge_hdr_defs.svh"


module bridge_header_bus_io_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic i_clk, // Core clock, 100 MHz
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] i_addr, // Byte address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_byte_en, // Byte lane enables
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, cycle after read
    input wire logic i_cap_unlock, // Capability bit writable
    input wire logic [3:0] i_io_window_top, // Limit field A[15:12]
    input wire logic i_io_check, // Range check request
    input wire logic [31:0] i_io_addr, // I/O address to check
    output logic o_io_check_done, // Check result valid pulse
    output logic o_io_forward, // Address inside window
    output logic o_io_limit_cap, // Capability for limit byte
    output logic [7:0] o_downstream_bus_number, // Secondary bus
    output logic [7:0] o_highest_bus_number // Subordinate bus
);

    // ======================================================
    // Elaboration checks
    generate
        if (ADDR_W < `MIN_ADDR_W) begin : g_bad_addr
            $error("address too narrow for the header offsets");
        end
    endgenerate

    // ======================================================
    // Word decode
    localparam int WA_W = ADDR_W - `WORD_LSB;

    logic [WA_W-1:0] word_addr;
    logic wr_timers;
    logic wr_busnum;
    logic wr_io_window_base;
    logic rd_timers;
    logic rd_base_address_zero;
    logic rd_base_address_one;
    logic rd_busnum;
    logic rd_io_window_base;

    // Turns a printed byte offset into its word index
    function automatic logic [WA_W-1:0] word_of(input logic [7:0] off);
        logic [7:0] idx;
        idx = off >> `WORD_LSB;
        return WA_W'(idx);
    endfunction

    // Lane of a printed byte offset
    function automatic logic [1:0] lane_of(input logic [7:0] off);
        return off[1:0];
    endfunction

    assign word_addr = i_addr[ADDR_W-1:`WORD_LSB];

    // Which word an access lands on
    assign rd_timers = word_addr == word_of(`OFF_PRIMARY_LATENCY_TIMER);
    assign rd_base_address_zero = word_addr == word_of(`OFF_BASE_ADDRESS_ZERO);
    assign rd_base_address_one = word_addr == word_of(`OFF_BASE_ADDRESS_ONE);
    assign rd_busnum = word_addr == word_of(`OFF_UPSTREAM_BUS_NUMBER);
    assign rd_io_window_base = word_addr == word_of(`OFF_IO_WINDOW_BASE);

    // Writes only matter for words with writable bytes
    assign wr_timers = i_wr && rd_timers;
    assign wr_busnum = i_wr && rd_busnum;
    assign wr_io_window_base = i_wr && rd_io_window_base;

    // ======================================================
    // Byte lane steering
    bridge_hdr_pkg::cfg_byte_type wbyte [`LANES];
    bridge_hdr_pkg::lane_en_type lane_en;

    // Split write data into lanes
    always_comb begin
        for (int l = 0; l < `LANES; l++) begin
            wbyte[l] = i_wdata[l*`BYTE_W +: `BYTE_W];
        end
    end

    assign lane_en = i_byte_en;

    // Write enables of the individual byte fields
    logic we_upstream;
    logic we_downstream;
    logic we_highest;
    logic we_io_window_base;
    logic we_cap;

    assign we_upstream = wr_busnum
        && lane_en[lane_of(`OFF_UPSTREAM_BUS_NUMBER)];
    assign we_downstream = wr_busnum
        && lane_en[lane_of(`OFF_DOWNSTREAM_BUS_NUMBER)];
    assign we_highest = wr_busnum
        && lane_en[lane_of(`OFF_HIGHEST_BUS_NUMBER)];
    assign we_io_window_base = wr_io_window_base
        && lane_en[lane_of(`OFF_IO_WINDOW_BASE)];
    assign we_cap = we_io_window_base && i_cap_unlock;

    // ======================================================
    // Writable fields
    bridge_hdr_pkg::cfg_byte_type upstream_bus;
    bridge_hdr_pkg::cfg_byte_type downstream_bus;
    bridge_hdr_pkg::cfg_byte_type highest_bus;
    logic [3:0] io_base_field;
    logic [0:0] io_cap_q;
    bridge_hdr_pkg::io_mode_type io_mode;

    // Primary bus number, software bookkeeping only
    byte_field_reg #(
        .WIDTH(`BYTE_W),
        .RESET_VAL(`RST_UPSTREAM_BUS_NUMBER)
    ) u_upstream_bus (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_upstream),
        .i_d(wbyte[lane_of(`OFF_UPSTREAM_BUS_NUMBER)]),
        .o_q(upstream_bus)
    );

    // Secondary bus number
    byte_field_reg #(
        .WIDTH(`BYTE_W),
        .RESET_VAL(`RST_DOWNSTREAM_BUS_NUMBER)
    ) u_downstream_bus (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_downstream),
        .i_d(wbyte[lane_of(`OFF_DOWNSTREAM_BUS_NUMBER)]),
        .o_q(downstream_bus)
    );

    // Subordinate bus number
    byte_field_reg #(
        .WIDTH(`BYTE_W),
        .RESET_VAL(`RST_HIGHEST_BUS_NUMBER)
    ) u_highest_bus (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_highest),
        .i_d(wbyte[lane_of(`OFF_HIGHEST_BUS_NUMBER)]),
        .o_q(highest_bus)
    );

    // I/O base address bits 15:12
    byte_field_reg #(
        .WIDTH(`IO_FIELD_MSB - `IO_FIELD_LSB + 1),
        .RESET_VAL(`RST_IO_BASE_FIELD)
    ) u_io_base (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_io_window_base),
        .i_d(wbyte[lane_of(`OFF_IO_WINDOW_BASE)]
            [`IO_FIELD_MSB:`IO_FIELD_LSB]),
        .o_q(io_base_field)
    );

    // I/O addressing capability, guarded by the unlock level
    byte_field_reg #(
        .WIDTH(1),
        .RESET_VAL(`RST_IO_CAPABILITY)
    ) u_io_cap (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_cap),
        .i_d(wbyte[lane_of(`OFF_IO_WINDOW_BASE)][`IO_CAP_BIT +: 1]),
        .o_q(io_cap_q)
    );

    assign io_mode = bridge_hdr_pkg::io_mode_type'(io_cap_q);

    // ======================================================
    // Read data assembly
    logic [31:0] rd_word;
    logic [31:0] rd_mask;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    bridge_hdr_pkg::cfg_byte_type io_base_byte;

    // I/O base byte image, reserved bits forced low
    assign io_base_byte = {io_base_field, `IO_RSVD_VAL,
        io_cap_q};

    // Word image of the addressed location
    always_comb begin
        rd_word = '0;
        if (rd_timers) begin
            rd_word[lane_of(`OFF_PRIMARY_LATENCY_TIMER)*`BYTE_W +: `BYTE_W]
                = `VAL_PRIMARY_LATENCY_TIMER;
            rd_word[lane_of(`OFF_HEADER_LAYOUT_TYPE)*`BYTE_W +: `BYTE_W]
                = `VAL_HEADER_LAYOUT_TYPE;
            rd_word[lane_of(`OFF_SELF_TEST_CONTROL)*`BYTE_W +: `BYTE_W]
                = `VAL_SELF_TEST_CONTROL;
        end else if (rd_base_address_zero) begin
            rd_word = `VAL_BASE_ADDRESS;
        end else if (rd_base_address_one) begin
            rd_word = `VAL_BASE_ADDRESS;
        end else if (rd_busnum) begin
            rd_word[lane_of(`OFF_UPSTREAM_BUS_NUMBER)*`BYTE_W +: `BYTE_W]
                = upstream_bus;
            rd_word[lane_of(`OFF_DOWNSTREAM_BUS_NUMBER)*`BYTE_W +: `BYTE_W]
                = downstream_bus;
            rd_word[lane_of(`OFF_HIGHEST_BUS_NUMBER)*`BYTE_W +: `BYTE_W]
                = highest_bus;
            rd_word[lane_of(`OFF_DOWNSTREAM_LATENCY_TIMER)*`BYTE_W +:
                `BYTE_W] = `VAL_DOWNSTREAM_LATENCY_TIMER;
        end else if (rd_io_window_base) begin
            rd_word[lane_of(`OFF_IO_WINDOW_BASE)*`BYTE_W +: `BYTE_W]
                = io_base_byte;
        end
    end

    // Disabled lanes return zero
    always_comb begin
        for (int l = 0; l < `LANES; l++) begin
            rd_mask[l*`BYTE_W +: `BYTE_W] = {`BYTE_W{lane_en[l]}};
        end
    end

    assign rdata_nxt = i_rd ? (rd_word & rd_mask) : '0;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ======================================================
    // I/O forwarding window
    logic [15:0] io_low;
    logic [15:0] io_high;
    logic io_upper_ok;
    logic io_inside;
    logic forward_nxt;
    logic forward_r;
    logic check_done_r;

    // Window bounds from base and limit fields
    assign io_low = {io_base_field, `IO_LOW_FILL};
    assign io_high = {i_io_window_top, `IO_HIGH_FILL};

    // Upper halves live outside; taken as zero in either mode
    assign io_upper_ok = (io_mode == bridge_hdr_pkg::SIXTEEN_BIT_IO_MODE)
        ? (i_io_addr[31:16] == `IO_UPPER_ZERO)
        : (i_io_addr[31:16] == `IO_UPPER_ZERO);

    assign io_inside = io_upper_ok
        && (i_io_addr[15:0] >= io_low)
        && (i_io_addr[15:0] <= io_high);

    assign forward_nxt = i_io_check ? io_inside : forward_r;

    // Forward decision, held until the next check
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            forward_r <= 1'b0;
        end else begin
            forward_r <= forward_nxt;
        end
    end

    // Result-valid pulse one cycle after the request
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            check_done_r <= 1'b0;
        end else begin
            check_done_r <= i_io_check;
        end
    end

    assign o_io_forward = forward_r;
    assign o_io_check_done = check_done_r;

    // ======================================================
    // Values seen by neighbouring header logic
    assign o_io_limit_cap = io_cap_q[0];
    assign o_downstream_bus_number = downstream_bus;
    assign o_highest_bus_number = highest_bus;

endmodule

/* File: testbench/bridge_header_bus_io_regs_checker.sv */
`timescale 1ns/10ps

// ==========================================================
// Port-level checks of the header register bank
module bridge_header_bus_io_regs_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic i_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] i_addr, // Byte address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_byte_en, // Lane enables
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic [31:0] o_rdata, // Read data
    input wire logic i_cap_unlock, // Capability unlock
    input wire logic [3:0] i_io_window_top, // Limit field
    input wire logic i_io_check, // Range check request
    input wire logic [31:0] i_io_addr, // Checked address
    input wire logic o_io_check_done, // Check done pulse
    input wire logic o_io_forward, // Inside window
    input wire logic o_io_limit_cap, // Limit byte capability
    input wire logic [7:0] o_downstream_bus_number, // Secondary bus
    input wire logic [7:0] o_highest_bus_number // Subordinate bus
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Strobes aimed at one word or one lane of the bus word
    sequence rd_word(int w);
        i_rd && i_addr[ADDR_W-1:2] == w;
    endsequence
    sequence wr_bus(int n);
        i_wr && i_addr[ADDR_W-1:2] == 6 && i_byte_en[n];
    endsequence

    chk_read_idle:
        assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    chk_hdr_word:
        assert property (rd_word(3) ##0 i_byte_en == 4'hF
            |=> o_rdata == 32'h0001_0000)
        else $error("header word wrong");
    chk_bar_zero:
        assert property (rd_word(4) or rd_word(5) |=> o_rdata == 32'h0)
        else $error("base address word not zero");
    chk_sec_latency:
        assert property (rd_word(6) |=> o_rdata[31:24] == 8'h00)
        else $error("secondary latency not zero");
    chk_rsvd_zero:
        assert property (rd_word(7) |=> o_rdata[31:1] == 31'h0
            || o_rdata[3:1] == 3'h0 && o_rdata[31:8] == 24'h0)
        else $error("reserved io base bits not zero");
    chk_cap_mirror:
        assert property (rd_word(7) ##0 i_byte_en[0]
            |=> o_rdata[0] == $past(o_io_limit_cap))
        else $error("limit capability differs from base");
    chk_sec_write:
        assert property (wr_bus(1)
            |=> o_downstream_bus_number == $past(i_wdata[15:8]))
        else $error("secondary bus not written");
    chk_sub_write:
        assert property (wr_bus(2)
            |=> o_highest_bus_number == $past(i_wdata[23:16]))
        else $error("subordinate bus not written");
    chk_bus_hold:
        assert property (!i_wr |=> $stable(o_downstream_bus_number)
            && $stable(o_highest_bus_number))
        else $error("bus number moved without write");
    chk_cap_lock:
        assert property (i_wr && !i_cap_unlock |=> $stable(o_io_limit_cap))
        else $error("capability changed while locked");
    chk_check_done:
        assert property (i_io_check |=> o_io_check_done)
        else $error("range check not answered");
    chk_fwd_hold:
        assert property (!i_io_check |=> !o_io_check_done
            && $stable(o_io_forward))
        else $error("forward result changed unasked");
    chk_fwd_outside:
        assert property (i_io_check && (i_io_addr[31:16] != 16'h0
            || i_io_addr[15:12] > i_io_window_top) |=> !o_io_forward)
        else $error("address above window forwarded");
endmodule

/* File: testbench/cfg_host_model.sv */
`timescale 1ns/10ps

// ==========================================================
// Configuration host issuing single-cycle register accesses
module cfg_host_model (
    input wire logic i_clk, // Core clock
    output logic [11:0] o_addr, // Byte address
    output logic [31:0] o_wdata, // Write data
    output logic [3:0] o_byte_en, // Lane enables
    output logic o_wr, // Write strobe
    output logic o_rd // Read strobe
);
    // Idle bus at time zero
    initial begin
        o_addr = 12'h000;
        o_wdata = 32'h0;
        o_byte_en = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One write cycle; data scrambled once released
    task automatic write(logic [11:0] a, logic [31:0] d, logic [3:0] e);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_byte_en <= e;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // One read cycle; the answer is watched by the bench
    task automatic read(logic [11:0] a, logic [3:0] e);
        @(posedge i_clk);
        o_addr <= a;
        o_byte_en <= e;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
    endtask
endmodule

/* File: testbench/bridge_header_bus_io_regs_test.sv */
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench of the header register bank
module bridge_header_bus_io_regs_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic wr, rd, done, fwd, lim_cap;
    logic rd_d = 1'b0;
    logic cap_unlock = 1'b0;
    logic [3:0] top = 4'h0;
    logic io_check = 1'b0;
    logic [31:0] io_addr = 32'h0;
    logic [7:0] dn_bus, hi_bus, up_s, dn_s, hi_s;
    logic [3:0] base_s;
    logic cap_s;
    logic [31:0] rd_q[$];
    logic io_q[$];
    logic [31:0] pts[6] = '{32'h0000_2FFF, 32'h0000_3000, 32'h0000_5FFF,
        32'h0000_6000, 32'h0001_3000, 32'h0000_4ABC};
    int fail_count = 0;
    int samples_checked = 0;

    always #5 i_clk = ~i_clk;

    cfg_host_model u_cfg_host_model (.i_clk(i_clk), .o_addr(addr),
        .o_wdata(wdata), .o_byte_en(be), .o_wr(wr), .o_rd(rd));

    bridge_header_bus_io_regs #(.ADDR_W(12)) u_bridge_header_bus_io_regs (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_byte_en(be), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_cap_unlock(cap_unlock), .i_io_window_top(top),
        .i_io_check(io_check), .i_io_addr(io_addr), .o_io_check_done(done),
        .o_io_forward(fwd), .o_io_limit_cap(lim_cap),
        .o_downstream_bus_number(dn_bus), .o_highest_bus_number(hi_bus));

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Expected read word from the shadow registers
    function automatic logic [31:0] model_rd(logic [11:0] a, logic [3:0] e);
        logic [31:0] w;
        case (a[11:2])
            10'h003: w = 32'h0001_0000;
            10'h006: w = {8'h00, hi_s, dn_s, up_s};
            10'h007: w = {24'h0, base_s, 3'h0, cap_s};
            default: w = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (!e[i]) w[8*i +: 8] = 8'h00;
        end
        return w;
    endfunction

    // Write with shadow update
    task automatic cw(logic [11:0] a, logic [31:0] d, logic [3:0] e);
        if (a[11:2] == 10'h006) begin
            if (e[0]) up_s = d[7:0];
            if (e[1]) dn_s = d[15:8];
            if (e[2]) hi_s = d[23:16];
        end
        if (a[11:2] == 10'h007 && e[0]) begin
            base_s = d[7:4];
            if (cap_unlock) cap_s = d[0];
        end
        u_cfg_host_model.write(a, d, e);
    endtask

    task automatic cr(logic [11:0] a, logic [3:0] e);
        rd_q.push_back(model_rd(a, e));
        u_cfg_host_model.read(a, e);
    endtask

    // Range check request, left raised for back-to-back use
    task automatic io(logic [31:0] a);
        io_q.push_back(a[31:16] == 16'h0 && a[15:0] >= {base_s, 12'h000}
            && a[15:0] <= {top, 12'hFFF});
        @(posedge i_clk);
        io_check <= 1'b1;
        io_addr <= a;
    endtask

    task automatic reset_shadow();
        up_s = 8'h00;
        dn_s = 8'h00;
        hi_s = 8'h00;
        base_s = 4'hF;
        cap_s = 1'b1;
    endtask

    // Answer watcher: oldest note against each result
    always @(posedge i_clk) begin
        if (rd_d) check("read data", rdata, rd_q.pop_front());
        if (done) begin
            check("forward", 32'(fwd), 32'(io_q.pop_front()));
        end
        rd_d <= rd;
    end

    initial begin
        void'($urandom(32'h5C4A));
        reset_shadow();
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int w = 3; w < 8; w++) begin
            cr(12'(w * 4), 4'hF);
        end
        @(negedge i_clk);
        check("limit cap", 32'(lim_cap), 32'h1);
        $display("Test reset values done");
        for (int w = 3; w < 6; w++) cw(12'(w * 4), 32'hFFFF_FFFF, 4'hF);
        cw(12'h01B, 32'hFF00_0000, 4'h8);
        for (int w = 3; w < 7; w++) cr(12'(w * 4), 4'hF);
        $display("Test read-only bytes done");
        repeat (6) begin
            cw(12'h018, $urandom, 4'($urandom));
            @(negedge i_clk);
            check("secondary bus", 32'(dn_bus), 32'(dn_s));
            check("subordinate bus", 32'(hi_bus), 32'(hi_s));
            cr(12'h018, 4'($urandom));
        end
        $display("Test bus numbers done");
        cw(12'h01C, 32'hFFFF_FFFF, 4'hF);
        cr(12'h01C, 4'hF);
        @(negedge i_clk);
        cap_unlock = 1'b1;
        cw(12'h01C, 32'h0000_0030, 4'h1);
        @(negedge i_clk);
        check("limit cap", 32'(lim_cap), 32'h0);
        cr(12'h01C, 4'h1);
        cap_unlock <= 1'b0;
        $display("Test io base byte done");
        @(negedge i_clk);
        top = 4'h5;
        foreach (pts[i]) io(pts[i]);
        @(posedge i_clk);
        io_check <= 1'b0;
        @(negedge i_clk);
        top = 4'h2;
        io(32'h0000_3000);
        @(posedge i_clk);
        io_check <= 1'b0;
        $display("Test io window done");
        cw(12'h040, 32'hFFFF_FFFF, 4'hF);
        cr(12'h040, 4'hF);
        cr(12'h018, 4'hF);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        reset_shadow();
        @(negedge i_clk);
        i_rst_n = 1'b1;
        cr(12'h018, 4'hF);
        cr(12'h01C, 4'hF);
        $display("Test unmapped and second reset done");
        repeat (3) @(posedge i_clk);
        check("pending notes", 32'(rd_q.size() + io_q.size()), 32'h0);
        give_verdict();
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge i_clk);
        fail_count++;
        give_verdict();
    end
endmodule

bind bridge_header_bus_io_regs bridge_header_bus_io_regs_checker #(
    .ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_byte_en(i_byte_en),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cap_unlock(i_cap_unlock), .i_io_window_top(i_io_window_top),
    .i_io_check(i_io_check), .i_io_addr(i_io_addr),
    .o_io_check_done(o_io_check_done), .o_io_forward(o_io_forward),
    .o_io_limit_cap(o_io_limit_cap),
    .o_downstream_bus_number(o_downstream_bus_number),
    .o_highest_bus_number(o_highest_bus_number));
